// *** design/sfwdg_top.sv ***
// sfwdg_top: software fault watchdog with APB registers
// assumes chip reset loops back to presetn; options are static straps
//
// Contract
// - counter decrements once per 49,152 machine cycles, 64 steps usable
// - active and counter 40h to 3Fh starts a chip reset
// - watchdog reset drives reset pin low for a fixed pulse
// - counter runs whether or not watchdog is active
// - reset leaves watchdog inactive; writes cannot deactivate it
// - write with activate set and top bit clear resets at once
// - hardware option makes watchdog always active
// - wait mode has no effect on the watchdog
// - reset-on-halt option with active watchdog resets on halt
// - without that option halt freezes counter, no reset
// - wake by interrupt resumes counting after 4096 clocks
// - register: activate bit 7, counter bits 6:0, reset 0 and 7Fh
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
module sfwdg_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// option straps and cpu events
	input wire logic opt_hw_watchdog,
	input wire logic opt_reset_on_halt,
	input wire logic cpu_wait,
	// reset pin, open drain
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic reset_request
);
	import sfwdg_pkg::*;

	sfwdg_tick_if tk ();

	logic [6:0] cnt_q, cnt_d;
	logic act_q;
	logic hw_q, roh_q;
	logic [1:0] strap_q;
	sfwdg_mode_t mode_q;
	logic [11:0] wake_q;
	logic [7:0] pulse_q;
	logic [31:0] prdata_q;
	logic rp_s1_q, rp_s2_q;
	logic wait_s1_q, wait_s2_q;

	// apb decode; slave answers in the access cycle with no wait
	wire acc_w = psel & penable;
	wire wr_w = acc_w & pwrite;
	wire rd_w = acc_w & ~pwrite;
	wire hit_ctrl_w = (paddr == SFWDG_CTRL_OFFSET);
	wire hit_opt_w = (paddr == SFWDG_OPT_OFFSET);
	wire hit_halt_w = (paddr == SFWDG_HALT_OFFSET);
	wire mapped_w = hit_ctrl_w | hit_opt_w | hit_halt_w;
	wire ctrl_wr_w = wr_w & hit_ctrl_w;
	wire halt_wr_w = wr_w & hit_halt_w;
	wire halt_req_w = halt_wr_w & pwdata[0];
	wire wake_req_w = halt_wr_w & pwdata[1];
	assign pready = 1'b1;
	assign pslverr = acc_w & ~mapped_w;

	// effective activation; straps ignore the software bit
	wire active_w = act_q | hw_q;
	wire new_act_w = act_q | (ctrl_wr_w & pwdata[SFWDG_ACT_BIT]);
	wire counting_w = (mode_q == SFWDG_RUN);
	assign tk.run = counting_w;
	wire roll_w = tk.tick & (cnt_q == SFWDG_CNT_TRIP);
	// software reset: activated write with top bit low
	wire sw_rst_w = ctrl_wr_w & (new_act_w | hw_q)
		& ~pwdata[SFWDG_TOP_BIT];
	wire halt_rst_w = halt_req_w & roh_q & active_w;
	wire fire_w = (active_w & roll_w) | sw_rst_w | halt_rst_w;
	wire pulsing_w = (pulse_q != 8'h00);

	sfwdg_prescaler #(.DIVIDE(SFWDG_PRESCALE)) u_pres (
		.pclk(pclk),
		.presetn(presetn),
		.tk(tk)
	);

	// counter next value; a write wins over a step
	always_comb begin
		cnt_d = cnt_q;
		if (ctrl_wr_w) begin
			cnt_d = pwdata[6:0];
		end else if (tk.tick) begin
			cnt_d = cnt_q - 7'h01;
		end
	end

	// straps sampled after release, not inside the reset branch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_q <= 2'h0;
			hw_q <= 1'b0;
			roh_q <= 1'b0;
		end else begin
			strap_q <= {opt_reset_on_halt, opt_hw_watchdog};
			hw_q <= strap_q[0];
			roh_q <= strap_q[1];
		end
	end

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= SFWDG_CNT_RESET;
			act_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			act_q <= new_act_w;
		end
	end

	// halt and wake sequence; wait input is deliberately unused here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= SFWDG_RUN;
			wake_q <= 12'h000;
		end else begin
			unique case (mode_q)
			SFWDG_RUN: begin
				if (halt_req_w && !halt_rst_w) begin
					mode_q <= SFWDG_HALT;
				end
			end
			SFWDG_HALT: begin
				if (wake_req_w) begin
					mode_q <= SFWDG_WAKE;
					wake_q <= 12'h000;
				end
			end
			SFWDG_WAKE: begin
				wake_q <= wake_q + 12'h001;
				if (wake_q == 12'(SFWDG_WAKE_CYCLES - 1)) begin
					mode_q <= SFWDG_RUN;
				end
			end
			default: begin // unused code returns to counting
				mode_q <= SFWDG_RUN;
			end
			endcase
		end
	end

	// reset pulse; counted on pclk so it survives until the pin drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_q <= 8'h00;
		end else if (fire_w && !pulsing_w) begin
			pulse_q <= 8'(SFWDG_PULSE_CYCLES);
		end else if (pulsing_w) begin
			pulse_q <= pulse_q - 8'h01;
		end
	end
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = pulsing_w;
	assign reset_request = pulsing_w;

	// pin level is read back through two flops for status only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rp_s1_q <= 1'b1;
			rp_s2_q <= 1'b1;
			wait_s1_q <= 1'b0;
			wait_s2_q <= 1'b0;
		end else begin
			rp_s1_q <= reset_pin_in;
			rp_s2_q <= rp_s1_q;
			wait_s1_q <= cpu_wait; // reported only, never gates
			wait_s2_q <= wait_s1_q;
		end
	end

	// read data registered for the next access
	wire [31:0] rd_ctrl_w = {24'h000000, act_q, cnt_q};
	wire [31:0] rd_opt_w = {26'h0000000, wait_s2_q, rp_s2_q, mode_q, roh_q,
		hw_q};
	wire [31:0] rd_mux_w = hit_ctrl_w ? rd_ctrl_w :
		hit_opt_w ? rd_opt_w : 32'h00000000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= rd_mux_w;
		end
	end
	assign prdata = prdata_q;

	// independent count of wake cycles, so the resume check does not
	// lean on the sequencer's own counter
	logic [12:0] wake_seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_seen_q <= 13'h0000;
		end else if (mode_q == SFWDG_WAKE) begin
			wake_seen_q <= wake_seen_q + 13'h0001;
		end else begin
			wake_seen_q <= 13'h0000;
		end
	end

	// counter and activation state
	a_act_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(act_q) |-> act_q)
		else $error("activation bit cleared without reset");
	a_act_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		(ctrl_wr_w && pwdata[SFWDG_ACT_BIT]) |=> act_q)
		else $error("activation write did not set the bit");
	a_act_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!act_q && !(ctrl_wr_w && pwdata[SFWDG_ACT_BIT])) |=> !act_q)
		else $error("activation set without a write");
	a_step_dec: assert property (
		@(posedge pclk) disable iff (!presetn)
		(tk.tick && !ctrl_wr_w) |=> cnt_q == $past(cnt_q) - 7'h01)
		else $error("counter did not step down");
	a_write_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctrl_wr_w |=> cnt_q == $past(pwdata[6:0]))
		else $error("write did not load counter");
	a_read_ctrl: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_ctrl_w) |=>
		prdata == {24'h000000, $past(act_q), $past(cnt_q)})
		else $error("control read data wrong");

	// reset generation
	a_roll_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		(act_q && tk.tick && cnt_q == SFWDG_CNT_TRIP && !pulsing_w)
		|=> reset_pin_oe)
		else $error("no reset on 40h to 3Fh roll");
	a_hw_active: assert property (
		@(posedge pclk) disable iff (!presetn)
		(hw_q && tk.tick && cnt_q == SFWDG_CNT_TRIP && !pulsing_w)
		|=> reset_request)
		else $error("hardware option roll did not reset");
	a_sw_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		(sw_rst_w && !pulsing_w) |=> reset_pin_oe ##1 reset_pin_oe)
		else $error("software reset missing");
	a_halt_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		(halt_req_w && roh_q && active_w && !pulsing_w) |=> reset_request)
		else $error("halt did not reset");
	a_pulse_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(reset_pin_oe) |-> reset_pin_oe [*8])
		else $error("reset pulse too short");
	a_pulse_end: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(reset_request) |-> $past(pulse_q) == 8'h01)
		else $error("reset pulse ended early");
	a_pulse_cause: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(reset_request) |-> $past(fire_w))
		else $error("reset request without a cause");
	a_no_spurious: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!fire_w && !pulsing_w) |=> !reset_request)
		else $error("reset request raised while idle");

	// halt and wake
	a_halt_enter: assert property (
		@(posedge pclk) disable iff (!presetn)
		(halt_req_w && mode_q == SFWDG_RUN && !(roh_q && (act_q || hw_q)))
		|=> mode_q == SFWDG_HALT)
		else $error("halt not entered");
	a_halt_refused: assert property (
		@(posedge pclk) disable iff (!presetn)
		(halt_req_w && mode_q == SFWDG_RUN && roh_q && (act_q || hw_q))
		|=> mode_q == SFWDG_RUN)
		else $error("halt entered although it must reset");
	a_halt_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q == SFWDG_HALT && !wake_req_w) |=> mode_q == SFWDG_HALT)
		else $error("halt left without a wake");
	a_halt_freeze: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q != SFWDG_RUN && !ctrl_wr_w) |=> cnt_q == $past(cnt_q))
		else $error("counter stepped during halt or wake");
	a_wake_exit: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q == SFWDG_HALT && wake_req_w) |=> mode_q == SFWDG_WAKE)
		else $error("wake request ignored");
	a_wake_delay: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(mode_q == SFWDG_WAKE) |-> !counting_w [*8])
		else $error("counting resumed early");
	a_wake_length: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q == SFWDG_WAKE) |=> counting_w ==
		($past(wake_seen_q) == 13'(SFWDG_WAKE_CYCLES - 1)))
		else $error("wake delay length wrong");
endmodule

// *** design/sfwdg_pkg.sv ***
// sfwdg_pkg: constants shared by the software fault watchdog files
// assumes a single pclk domain at 20 MHz and an APB register port
package sfwdg_pkg;
	localparam logic [11:0] SFWDG_CTRL_OFFSET = 12'h00C; // watchdog_control
	localparam logic [11:0] SFWDG_OPT_OFFSET = 12'h010; // option and status
	localparam logic [11:0] SFWDG_HALT_OFFSET = 12'h014; // halt and wake strobes
	localparam int SFWDG_ACT_BIT = 7;
	localparam int SFWDG_TOP_BIT = 6;
	localparam logic [6:0] SFWDG_CNT_RESET = 7'h7F;
	localparam logic [6:0] SFWDG_CNT_TRIP = 7'h40;
	localparam int SFWDG_PRESCALE = 49152;
	localparam int SFWDG_WAKE_CYCLES = 4096;
	localparam int SFWDG_PULSE_NS = 500; // reset_pulse_length, plain default
	localparam int SFWDG_CLK_NS = 50;
	localparam int SFWDG_PULSE_CYCLES =
		(SFWDG_PULSE_NS + SFWDG_CLK_NS - 1) / SFWDG_CLK_NS;
	typedef enum logic [1:0] {SFWDG_RUN, SFWDG_HALT, SFWDG_WAKE}
		sfwdg_mode_t;
endpackage

// *** design/sfwdg_tick_if.sv ***
// sfwdg_tick_if: count control between watchdog top and prescaler
// assumes both ends share pclk
`timescale 1ns/100ps
interface sfwdg_tick_if;
	logic run;
	logic tick;
	modport ctrl (output run, input tick);
	modport pres (input run, output tick);
endinterface

// *** design/sfwdg_prescaler.sv ***
// sfwdg_prescaler: divides pclk machine cycles down to counter steps
// assumes run from the top; holds its count while run is low
`timescale 1ns/100ps
module sfwdg_prescaler #(
	parameter int DIVIDE = sfwdg_pkg::SFWDG_PRESCALE
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// step control
	sfwdg_tick_if.pres tk
);
	import sfwdg_pkg::*;
	logic [16:0] cnt_q;
	wire last_w = (cnt_q == 17'(DIVIDE - 1));
	// frozen count resumes where it stopped, never restarts a step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 17'h00000;
		end else if (tk.run) begin
			cnt_q <= last_w ? 17'h00000 : cnt_q + 17'h00001;
		end
	end
	assign tk.tick = tk.run & last_w;
endmodule

// *** test/sfwdg_top_bench.sv ***
// sfwdg_top_bench: self-checking bench for the software fault watchdog
// assumes a zero-wait apb slave and one pclk domain; drives all inputs
`timescale 1ns/100ps
module sfwdg_top_bench;
	import sfwdg_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, rp_out, rp_oe, rst_req;
	logic opt_hw = 0, opt_roh = 0, cpu_wait = 0;
	logic [31:0] seed = 32'h0000B7EF, r;
	int n_errors = 0, n_compared = 0;
	// reset pin has a pull-up, so it reads high unless pulled low
	wire pin = rp_oe ? rp_out : 1'b1;
	sfwdg_top u_sfwdg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.opt_hw_watchdog(opt_hw), .opt_reset_on_halt(opt_roh),
		.cpu_wait(cpu_wait), .reset_pin_in(pin), .reset_pin_out(rp_out),
		.reset_pin_oe(rp_oe), .reset_request(rst_req));
	always #25 pclk = ~pclk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// activate bit is sticky, counter bits load from the write
	function automatic logic [31:0] exp_ctrl(input logic act,
		input logic [7:0] w);
		return {24'h0, act | w[7], w[6:0]};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task final_report();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// one apb transfer; an idle edge first so no signal is set twice
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			n_errors++;
			$display("[ERR] %0t apb transfer timed out", $time);
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task reset_dut();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	// counts request and pin low cycles, sampled mid-cycle where settled;
	// ends on a rising edge so the caller drives inputs from there
	task watch(input int n, input int exp);
		int i, c, p;
		c = 0;
		p = 0;
		for (i = 0; i < n; i++) begin
			@(negedge pclk);
			if (rst_req === 1'b1) c++;
			if (pin === 1'b0) p++;
		end
		@(posedge pclk);
		chk(c, exp);
		chk(p, exp);
	endtask
	initial begin
		reset_dut();
		apb(0, SFWDG_CTRL_OFFSET, 0);
		chk(rd, 32'h0000007F);
		apb(0, SFWDG_OPT_OFFSET, 0);
		chk(rd & 32'h1F, 32'h10);
		apb(0, 12'h020, 0);
		chk({err, rd[30:0]}, 32'h80000000);
		$display("reset values done");
		// random refresh values with activate clear, wait mode toggling
		repeat (6) begin
			r = xs();
			cpu_wait <= r[8];
			apb(1, SFWDG_CTRL_OFFSET, {24'h0, 2'b01, r[5:0]});
			apb(0, SFWDG_CTRL_OFFSET, 0);
			chk(rd, exp_ctrl(1'b0, {2'b01, r[5:0]}));
			apb(0, SFWDG_OPT_OFFSET, 0);
			chk(rd & 32'h20, {26'h0, r[8], 5'h0});
		end
		$display("refresh done");
		r = xs();
		apb(1, SFWDG_CTRL_OFFSET, {24'h0, 2'b10, r[5:0]});
		watch(40, SFWDG_PULSE_CYCLES);
		reset_dut();
		apb(1, SFWDG_CTRL_OFFSET, 32'hFF);
		apb(1, SFWDG_CTRL_OFFSET, 32'h7F);
		apb(0, SFWDG_CTRL_OFFSET, 0);
		chk(rd, exp_ctrl(1'b1, 8'h7F));
		// random activated refreshes between FFh and C0h
		repeat (4) begin
			r = xs();
			apb(1, SFWDG_CTRL_OFFSET, {24'h0, 2'b11, r[5:0]});
			apb(0, SFWDG_CTRL_OFFSET, 0);
			chk(rd, exp_ctrl(1'b1, {2'b11, r[5:0]}));
		end
		watch(20, 0);
		$display("activation done");
		opt_roh <= 1'b1;
		reset_dut();
		apb(1, SFWDG_CTRL_OFFSET, 32'hFF);
		apb(1, SFWDG_HALT_OFFSET, 32'h1);
		watch(40, SFWDG_PULSE_CYCLES);
		opt_roh <= 1'b0;
		reset_dut();
		apb(1, SFWDG_CTRL_OFFSET, 32'hFF);
		apb(1, SFWDG_HALT_OFFSET, 32'h1);
		apb(0, SFWDG_OPT_OFFSET, 0);
		chk(rd & 32'hC, 32'h4);
		watch(30, 0);
		apb(1, SFWDG_HALT_OFFSET, 32'h2);
		repeat (SFWDG_WAKE_CYCLES - 20) @(posedge pclk);
		apb(0, SFWDG_OPT_OFFSET, 0);
		chk(rd & 32'hC, 32'h8);
		repeat (30) @(posedge pclk);
		apb(0, SFWDG_OPT_OFFSET, 0);
		chk(rd & 32'hC, 32'h0);
		$display("halt done");
		// inactive roll from 40h to 3Fh keeps counting without a reset
		reset_dut();
		apb(1, SFWDG_CTRL_OFFSET, 32'h40);
		watch(SFWDG_PRESCALE + 8, 0);
		apb(0, SFWDG_CTRL_OFFSET, 0);
		chk(rd, 32'h0000003F);
		// hardware option: activate bit clear, roll still resets
		opt_hw <= 1'b1;
		reset_dut();
		apb(1, SFWDG_CTRL_OFFSET, 32'h40);
		watch(SFWDG_PRESCALE + 20, SFWDG_PULSE_CYCLES);
		$display("roll done");
		final_report();
	end
endmodule
